// file: include/kpm_pkg.sv
// shared constants and carrier types for the keypad, display and parameter menu block
package kpm_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int DEBOUNCE_TIME_US = 10_000;
  localparam int BLINK_TIME_MS = 250;
  localparam int DEBOUNCE_CYCLES_DEF = DEBOUNCE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int BLINK_CYCLES_DEF = BLINK_TIME_MS * (CLK_FREQ_HZ / 1_000);
  localparam int CNT_W = 24;

  // ****************************************************************
  // display and value layout
  // ****************************************************************
  localparam int NUM_DIGITS = 6;
  localparam int VAL_DIGITS = 5;
  localparam int VAL_W = 20;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_FIRST = 3'h0;
  localparam logic [SEL_W-1:0] SEL_LAST = 3'h4;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [VAL_W-1:0] PW_DEFAULT = 20'h00005;
  localparam logic [VAL_W-1:0] PW_DISABLED = 20'h00000;
  localparam logic [VAL_W-1:0] PW_DISABLE_RST = 20'h00001;
  localparam logic [VAL_W-1:0] SAVE_OFF = 20'h00000;
  localparam logic [VAL_W-1:0] SAVE_EN_RST = 20'h00001;
  localparam logic [VAL_W-1:0] PARAM_NUM_RST = 20'h00000;

  // glyph codes: 0..9 are the decimal digits themselves
  localparam logic [4:0] CH_A = 5'h0A;
  localparam logic [4:0] CH_B = 5'h0B;
  localparam logic [4:0] CH_D = 5'h0C;
  localparam logic [4:0] CH_E = 5'h0D;
  localparam logic [4:0] CH_F = 5'h0E;
  localparam logic [4:0] CH_P = 5'h0F;
  localparam logic [4:0] CH_T = 5'h10;
  localparam logic [4:0] CH_O = 5'h11;
  localparam logic [4:0] CH_U = 5'h12;
  localparam logic [4:0] CH_N = 5'h13;
  localparam logic [4:0] CH_S = 5'h14;
  localparam logic [4:0] CH_BLANK = 5'h15;
  localparam logic [6:0] SEG_BLANK = 7'h00;

  // ****************************************************************
  // register map (word index on the avalon address)
  // ****************************************************************
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] REG_PW_ENTRY = 3'h0;
  localparam logic [ADDR_W-1:0] REG_PW_DISABLE = 3'h1;
  localparam logic [ADDR_W-1:0] REG_NV_SAVE_EN = 3'h2;
  localparam logic [ADDR_W-1:0] REG_PW_STORED = 3'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {KPM_SEARCH, KPM_VIEW, KPM_MODIFY} kpm_mode_t;

  typedef struct packed {
    logic commit;
    logic dec;
    logic inc;
    logic shift;
  } kpm_keys_t;

  typedef struct packed {
    logic sto_active;
    logic fault;
    logic alarm;
    logic card_xfer;
    logic download;
    logic factory_load;
    logic card_erase;
    logic tune_active;
    logic tune_done;
    logic [3:0] tune_phase;
    logic [VAL_W-1:0] event_code;
  } kpm_stat_t;

  typedef struct packed {
    logic writable;
    logic online;
    logic [VAL_W-1:0] value;
  } kpm_param_t;

endpackage : kpm_pkg

// file: hdl/kpm_panel.sv
// keypad, six-digit display and parameter menu of the drive front panel
`timescale 1ns/1ps
// What this block does
// - six seven-segment digits, four keys
// - commit in search enters view or modify
// - editable online parameters apply at once, two modes
// - offline parameters: view mode, apply on commit
// - commit stores to nv unless save disabled
// - decrement steps number or lowers digit
// - increment steps number or raises digit
// - select in view returns to search
// - select advances flashing digit from one
// - reset key reinitializes all but stored password and bus slave
// - writes need matching password unless disabled
// - password defaults to five, commit+dec restores
// - select+increment at reset skips user program
// - search shows P then parameter number
// - modify flashes selected digit, first digit one
// - alarm shows A, fault shows F
// - card transfer flashes b in digit one
// - download flashes d in digit one
// - factory load flashes P in digit one
// - factory load with erase: P then E
// - tuning shows phase, then end message
// - safe torque off message when active
module kpm_panel
  import kpm_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF,
  parameter int BLINK_CYCLES = BLINK_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operator keys, active high while pressed
  input wire kpm_keys_t keys,
  input wire logic reset_key,
  // drive status for the special screens
  input wire kpm_stat_t stat,
  // parameter store
  input wire kpm_param_t param,
  output logic [VAL_W-1:0] param_num,
  output logic param_wr,
  output logic [VAL_W-1:0] param_wr_data,
  output logic nv_save,
  output logic no_app_start,
  // display, segments gfedcba, index 0 is digit one
  output logic [NUM_DIGITS-1:0][6:0] seg,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // one decimal digit up or down with wrap
  function automatic logic [3:0] digit_step(input logic [3:0] d, input logic up);
    return up ? ((d >= BCD_MAX) ? BCD_ZERO : d + 4'h1) : ((d == BCD_ZERO) ? BCD_MAX : d - 4'h1);
  endfunction : digit_step
  // whole bcd number up or down by one, carry or borrow rippling
  function automatic logic [VAL_W-1:0] bcd_step(input logic [VAL_W-1:0] v, input logic up);
    logic [VAL_W-1:0] r;
    logic ripple;
    r = v;
    ripple = 1'b1;
    for (int i = 0; i < VAL_DIGITS; i++) begin
      if (ripple) begin
        r[i*4 +: 4] = digit_step(v[i*4 +: 4], up);
        ripple = up ? (v[i*4 +: 4] >= BCD_MAX) : (v[i*4 +: 4] == BCD_ZERO);
      end
    end
    return r;
  endfunction : bcd_step
  // step only the selected digit, no carry into its neighbours
  function automatic logic [VAL_W-1:0] digit_adj(input logic [VAL_W-1:0] v, input logic [SEL_W-1:0] sel,
                                                 input logic up);
    logic [VAL_W-1:0] r;
    r = v;
    for (int i = 0; i < VAL_DIGITS; i++) begin
      if (sel == SEL_W'(i)) begin
        r[i*4 +: 4] = digit_step(v[i*4 +: 4], up);
      end
    end
    return r;
  endfunction : digit_adj
  // glyph code to segment pattern gfedcba
  function automatic logic [6:0] glyph(input logic [4:0] c);
    logic [6:0] s;
    s = SEG_BLANK;
    case (c)
      5'h00: s = 7'h3F;
      5'h01: s = 7'h06;
      5'h02: s = 7'h5B;
      5'h03: s = 7'h4F;
      5'h04: s = 7'h66;
      5'h05: s = 7'h6D;
      5'h06: s = 7'h7D;
      5'h07: s = 7'h07;
      5'h08: s = 7'h7F;
      5'h09: s = 7'h6F;
      CH_A: s = 7'h77;
      CH_B: s = 7'h7C;
      CH_D: s = 7'h5E;
      CH_E: s = 7'h79;
      CH_F: s = 7'h71;
      CH_P: s = 7'h73;
      CH_T: s = 7'h78;
      CH_O: s = 7'h5C;
      CH_U: s = 7'h1C;
      CH_N: s = 7'h54;
      CH_S: s = 7'h6D;
      default: s = SEG_BLANK;
    endcase
    return s;
  endfunction : glyph
  // ****************************************************************
  // reinitialization and startup key combinations
  // ****************************************************************
  logic core_rst_ff;
  logic strap_arm_ff;
  logic pw_restore_ff;
  logic no_app_ff;
  // the recessed key acts like a control supply cycle for all menu state
  always_ff @(posedge clk) begin
    core_rst_ff <= rst | reset_key;
  end
  // keys are sampled on the first cycle after reinitialization ends
  always_ff @(posedge clk) begin
    pw_restore_ff <= 1'b0;
    if (core_rst_ff) begin
      strap_arm_ff <= 1'b1;
    end else if (strap_arm_ff) begin
      strap_arm_ff <= 1'b0;
      pw_restore_ff <= keys.commit & keys.dec;
      no_app_ff <= keys.shift & keys.inc;
    end
    if (rst) begin
      no_app_ff <= 1'b0;
    end
  end
  // ****************************************************************
  // key debounce
  // ****************************************************************
  logic [3:0] key_raw;
  logic [3:0] key_stable_ff;
  logic [3:0] key_press_ff;
  logic [3:0][CNT_W-1:0] deb_cnt_ff;
  assign key_raw = keys;
  // a key must hold a new level for the whole window before it counts;
  // this costs response time but removes contact bounce entirely
  always_ff @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      key_press_ff[k] <= 1'b0;
      if (core_rst_ff || strap_arm_ff) begin
        key_stable_ff[k] <= 1'b1; // keys held through reset give no press
        deb_cnt_ff[k] <= '0;
      end else if (key_raw[k] == key_stable_ff[k]) begin
        deb_cnt_ff[k] <= '0;
      end else if (deb_cnt_ff[k] >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
        deb_cnt_ff[k] <= '0;
        key_stable_ff[k] <= key_raw[k];
        key_press_ff[k] <= key_raw[k];
      end else begin
        deb_cnt_ff[k] <= deb_cnt_ff[k] + CNT_W'(1);
      end
    end
  end
  kpm_keys_t press;
  assign press = key_press_ff;
  // ****************************************************************
  // software visible settings
  // ****************************************************************
  logic [VAL_W-1:0] pw_entry_ff;
  logic [VAL_W-1:0] pw_disable_ff;
  logic [VAL_W-1:0] save_en_ff;
  logic [VAL_W-1:0] pw_stored_ff;
  logic bus_req;
  logic bus_wr;
  logic unlocked;
  assign bus_req = avs_read | avs_write;
  assign bus_wr = avs_write & ~avs_waitrequest;
  assign unlocked = (pw_disable_ff == PW_DISABLED) || (pw_entry_ff == pw_stored_ff);
  // settings take effect on the accepting edge only
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      pw_entry_ff <= '0;
      pw_disable_ff <= PW_DISABLE_RST;
      save_en_ff <= SAVE_EN_RST;
    end else if (bus_wr) begin
      case (avs_address)
        REG_PW_ENTRY: pw_entry_ff <= avs_writedata[VAL_W-1:0];
        REG_PW_DISABLE: pw_disable_ff <= avs_writedata[VAL_W-1:0];
        REG_NV_SAVE_EN: save_en_ff <= avs_writedata[VAL_W-1:0];
        default: ;
      endcase
    end
  end
  // stored password survives the reset key unless the combination is held
  always_ff @(posedge clk) begin
    if (rst || pw_restore_ff) begin
      pw_stored_ff <= PW_DEFAULT;
    end else if (bus_wr && avs_address == REG_PW_STORED) begin
      pw_stored_ff <= avs_writedata[VAL_W-1:0];
    end
  end
  // ****************************************************************
  // parameter menu
  // ****************************************************************
  kpm_mode_t mode_ff;
  logic [SEL_W-1:0] sel_ff;
  logic [VAL_W-1:0] num_ff;
  logic [VAL_W-1:0] edit_ff;
  logic [VAL_W-1:0] nxt_edit;
  logic wr_ff;
  logic [VAL_W-1:0] wr_data_ff;
  logic save_ff;
  logic can_edit;
  assign can_edit = param.writable & unlocked;
  assign nxt_edit = digit_adj(edit_ff, sel_ff, press.inc);
  // one key acts per cycle: commit, then select, then increment, then decrement
  always_ff @(posedge clk) begin
    wr_ff <= 1'b0;
    save_ff <= 1'b0;
    if (core_rst_ff) begin
      mode_ff <= KPM_SEARCH;
      sel_ff <= SEL_FIRST;
      num_ff <= PARAM_NUM_RST;
      edit_ff <= '0;
      wr_data_ff <= '0;
    end else begin
      unique case (mode_ff)
        KPM_SEARCH: begin
          if (press.commit) begin
            edit_ff <= param.value;
            sel_ff <= SEL_FIRST;
            // online parameters that can be edited skip the read-only stop
            if (param.online && can_edit) begin
              mode_ff <= KPM_MODIFY;
            end else begin
              mode_ff <= KPM_VIEW;
            end
          end else if (press.inc) begin
            num_ff <= bcd_step(num_ff, 1'b1);
          end else if (press.dec) begin
            num_ff <= bcd_step(num_ff, 1'b0);
          end
        end
        KPM_VIEW: begin
          if (press.commit) begin
            edit_ff <= param.value;
            sel_ff <= SEL_FIRST;
            mode_ff <= can_edit ? KPM_MODIFY : KPM_SEARCH;
          end else if (press.shift) begin
            mode_ff <= KPM_SEARCH;
          end
        end
        KPM_MODIFY: begin
          if (press.commit) begin
            mode_ff <= KPM_SEARCH;
            wr_ff <= ~param.online;
            wr_data_ff <= edit_ff;
            save_ff <= (save_en_ff != SAVE_OFF);
          end else if (press.shift) begin
            sel_ff <= (sel_ff == SEL_LAST) ? SEL_FIRST : sel_ff + SEL_W'(1);
          end else if (press.inc || press.dec) begin
            edit_ff <= nxt_edit;
            // online values reach the drive on every step
            wr_ff <= param.online;
            wr_data_ff <= nxt_edit;
          end
        end
      endcase
    end
  end
  assign param_num = num_ff;
  assign param_wr = wr_ff;
  assign param_wr_data = wr_data_ff;
  assign nv_save = save_ff;
  assign no_app_start = no_app_ff;
  // ****************************************************************
  // display
  // ****************************************************************
  logic [CNT_W-1:0] blink_cnt_ff;
  logic blink_ff;
  logic [NUM_DIGITS-1:0][4:0] chars;
  logic [NUM_DIGITS-1:0] flash;
  logic [NUM_DIGITS-1:0][6:0] seg_ff;
  // shared blink phase for every flashing digit
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
    end else if (blink_cnt_ff >= CNT_W'(BLINK_CYCLES - 1)) begin
      blink_cnt_ff <= '0;
      blink_ff <= ~blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + CNT_W'(1);
    end
  end
  // screen choice, safety and fault screens first so they cannot be hidden
  always_comb begin
    chars = {NUM_DIGITS{CH_BLANK}};
    flash = '0;
    if (stat.sto_active) begin
      chars[2] = CH_S;
      chars[1] = CH_T;
      chars[0] = CH_O;
    end else if (stat.fault || stat.alarm) begin
      chars[5] = stat.fault ? CH_F : CH_A;
      for (int i = 0; i < VAL_DIGITS; i++) begin
        chars[i] = {1'b0, stat.event_code[i*4 +: 4]};
      end
    end else if (stat.card_xfer) begin
      chars[0] = CH_B;
      flash[0] = 1'b1;
    end else if (stat.download) begin
      chars[0] = CH_D;
      flash[0] = 1'b1;
    end else if (stat.factory_load || stat.card_erase) begin
      chars[0] = stat.card_erase ? CH_E : CH_P;
      flash[0] = 1'b1;
    end else if (stat.tune_active) begin
      chars[5] = CH_A;
      chars[4] = CH_U;
      chars[3] = CH_T;
      chars[2] = CH_O;
      chars[1] = 5'h00;
      chars[0] = {1'b0, stat.tune_phase};
    end else if (stat.tune_done) begin
      chars[2] = CH_E;
      chars[1] = CH_N;
      chars[0] = CH_D;
    end else begin
      unique case (mode_ff)
        KPM_SEARCH: begin
          chars[5] = CH_P;
          for (int i = 0; i < VAL_DIGITS; i++) begin
            chars[i] = {1'b0, num_ff[i*4 +: 4]};
          end
        end
        KPM_VIEW: begin
          for (int i = 0; i < VAL_DIGITS; i++) begin
            chars[i] = {1'b0, param.value[i*4 +: 4]};
          end
        end
        KPM_MODIFY: begin
          for (int i = 0; i < VAL_DIGITS; i++) begin
            chars[i] = {1'b0, edit_ff[i*4 +: 4]};
            flash[i] = (sel_ff == SEL_W'(i));
          end
        end
      endcase
    end
  end
  // registered segments, flashing digits go dark in the off phase
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_DIGITS; i++) begin
      if (core_rst_ff) begin
        seg_ff[i] <= SEG_BLANK;
      end else begin
        seg_ff[i] <= (flash[i] && blink_ff) ? SEG_BLANK : glyph(chars[i]);
      end
    end
  end
  assign seg = seg_ff;
  // ****************************************************************
  // avalon-mm slave
  // ****************************************************************
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  // every request waits exactly one cycle, then is accepted
  always_ff @(posedge clk) begin
    if (rst) begin
      waitreq_ff <= 1'b1;
      rdata_ff <= RD_UNMAPPED;
    end else if (bus_req && waitreq_ff) begin
      waitreq_ff <= 1'b0;
      unique case (avs_address)
        REG_PW_ENTRY: rdata_ff <= {12'h000, pw_entry_ff};
        REG_PW_DISABLE: rdata_ff <= {12'h000, pw_disable_ff};
        REG_NV_SAVE_EN: rdata_ff <= {12'h000, save_en_ff};
        REG_PW_STORED: rdata_ff <= {12'h000, pw_stored_ff};
        REG_STATUS: rdata_ff <= {4'h0, num_ff, 1'b0, sel_ff, no_app_ff, unlocked, mode_ff};
        default: rdata_ff <= RD_UNMAPPED;
      endcase
    end else begin
      waitreq_ff <= 1'b1;
    end
  end
  assign avs_waitrequest = waitreq_ff;
  assign avs_readdata = rdata_ff;
endmodule : kpm_panel

// file: verif/kpm_panel_assertions.sv
// checker of the front panel block port behaviour
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module kpm_panel_checker
  import kpm_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = 4,
  parameter int BLINK_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // keys and drive status
  input wire kpm_keys_t keys,
  input wire logic reset_key,
  input wire kpm_stat_t stat,
  // outputs under watch
  input wire logic param_wr,
  input wire logic nv_save,
  input wire logic no_app_start,
  input wire logic [NUM_DIGITS-1:0][6:0] seg,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // core reset lags the key by one edge, so two samples are needed
  a_key_reinit: assert property (reset_key [*2] |=> seg == '0 && !param_wr && !nv_save)
    else $error("reset key left outputs active");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_bus_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_wr_pulse: assert property (param_wr |=> !param_wr)
    else $error("parameter write longer than one cycle");
  a_nv_pulse: assert property (nv_save |=> !nv_save)
    else $error("store pulse longer than one cycle");
  a_strap_start: assert property ($rose(no_app_start) |-> $past(keys.shift && keys.inc))
    else $error("no-program start without key combination");
  a_sto_screen: assert property ((stat.sto_active && !reset_key) [*4] |-> seg[2] == 7'h6D)
    else $error("safe torque off screen missing");
  a_fault_letter: assert property ((stat.fault && !stat.sto_active && !reset_key) [*4] |-> seg[5] == 7'h71)
    else $error("fault letter missing");
  a_alarm_letter: assert property ((stat.alarm && !stat.fault && !stat.sto_active && !reset_key) [*4]
    |-> seg[5] == 7'h77)
    else $error("alarm letter missing");
endmodule : kpm_panel_checker

bind kpm_panel kpm_panel_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .keys(keys), .reset_key(reset_key), .stat(stat), .param_wr(param_wr),
  .nv_save(nv_save), .no_app_start(no_app_start), .seg(seg), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// file: verif/kpm_operator.sv
// operator model that presses the panel keys
`timescale 1ns/1ps
// ****************
// operator
// ****************
module kpm_operator
  import kpm_pkg::*;
#(
  parameter int HOLD = 8
) (
  // clock
  input wire logic clk,
  // keys and recessed reset key
  output kpm_keys_t keys,
  output logic reset_key
);
  // nothing pressed at power-up
  initial begin
    keys = '0;
    reset_key = 1'b0;
  end
  // puts a combination down and leaves it held
  task automatic hold(input kpm_keys_t k);
    @(posedge clk);
    keys <= k;
  endtask : hold
  // a press outlasts the debounce time both down and up
  task automatic press(input kpm_keys_t k);
    hold(k);
    repeat (HOLD) @(posedge clk);
    keys <= '0;
    repeat (HOLD) @(posedge clk);
  endtask : press
  // keys stay down across the reset so the strap sees them
  task automatic reset_push(input kpm_keys_t k);
    hold(k);
    reset_key <= 1'b1;
    repeat (4) @(posedge clk);
    reset_key <= 1'b0;
    repeat (4) @(posedge clk);
    keys <= '0;
    repeat (HOLD) @(posedge clk);
  endtask : reset_push
endmodule : kpm_operator

// file: verif/tb_kpm_panel.sv
// testbench of the front panel block
`timescale 1ns/1ps
// ****************
// bench
// ****************
module tb_kpm_panel;
  import kpm_pkg::*;
  localparam kpm_keys_t K_COM = 4'h8;
  localparam kpm_keys_t K_DEC = 4'h4;
  localparam kpm_keys_t K_INC = 4'h2;
  localparam kpm_keys_t K_SEL = 4'h1;
  localparam int TMO = 5000;
  localparam logic [2:0] IDX [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  localparam logic [31:0] DEF [5] = '{32'h0, 32'h1, 32'h1, 32'h5, 32'h0};
  logic clk, rst, reset_key, param_wr, nv_save, no_app_start, avs_read, avs_write, avs_waitrequest;
  kpm_keys_t keys;
  kpm_stat_t stat;
  kpm_stat_t s;
  kpm_param_t param;
  logic [VAL_W-1:0] param_num, param_wr_data, pval, last_wr;
  logic [NUM_DIGITS-1:0][6:0] seg;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int num_errors, checked, cyc, wr_cnt, nv_cnt;

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  kpm_panel #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(8)) DUT (.clk(clk), .rst(rst), .keys(keys),
    .reset_key(reset_key), .stat(stat), .param(param), .param_num(param_num), .param_wr(param_wr),
    .param_wr_data(param_wr_data), .nv_save(nv_save), .no_app_start(no_app_start), .seg(seg),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  kpm_operator op (.clk(clk), .keys(keys), .reset_key(reset_key));

  // one-value parameter store; odd numbers offline, even ones online, ending in 3 read-only
  always @(posedge clk) begin
    if (param_wr) begin
      pval <= param_wr_data;
      last_wr <= param_wr_data;
      wr_cnt <= wr_cnt + 1;
    end
    if (nv_save) nv_cnt <= nv_cnt + 1;
    param <= '{writable: (param_num[3:0] != 4'h3), online: ~param_num[0], value: pval};
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // avalon transfer; request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // status: selected digit, strap flag, unlock, mode
  task automatic st(input logic [1:0] m, input logic [2:0] sl, input logic u);
    bus(1'b0, REG_STATUS, 32'h0);
    check("status", {rd[6:2], rd[1:0]}, {sl, 1'b1, u, m});
  endtask : st

  task automatic key(input kpm_keys_t k);
    op.press(k);
    @(negedge clk);
  endtask : key

  // special screen: glyph must show, and blank too only when flashing
  task automatic scr(input kpm_stat_t v, input int i, input logic [6:0] g, input logic fl, input string nm);
    logic on, off;
    on = 1'b0;
    off = 1'b0;
    @(posedge clk);
    stat <= v;
    repeat (4) @(negedge clk);
    repeat (40) begin
      @(negedge clk);
      if (seg[i] === g) on = 1'b1;
      if (seg[i] === 7'h00) off = 1'b1;
    end
    check(nm, {on, off}, {1'b1, fl});
  endtask : scr

  task automatic results();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    rst = 1'b1;
    stat = '0;
    param = '0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    pval = 20'h00200;
    last_wr = '0;
    {num_errors, checked, cyc, wr_cnt, nv_cnt} = '0;
    op.hold(4'h3);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    op.press('0);
    @(negedge clk);
    check("no_app_start", no_app_start, 1'b1);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, IDX[i], 32'h0);
      check("reg", rd, DEF[i]);
    end
    bus(1'b1, 3'h5, 32'h7);
    bus(1'b0, 3'h5, 32'h0);
    check("unmapped", rd, 32'h0);
    @(negedge clk);
    check("d6", seg[5], 7'h73);
    check("d1", seg[0], 7'h3F);
    key(K_DEC);
    check("num", param_num, 20'h99999);
    key(K_INC);
    check("num", param_num, 20'h00000);
    key(K_INC);
    check("d1", seg[0], 7'h06);
    key(K_COM);
    st(2'h1, 3'h0, 1'b0);
    key(K_SEL);
    st(2'h0, 3'h0, 1'b0);
    bus(1'b1, REG_PW_ENTRY, 32'h5);
    key(K_COM);
    st(2'h1, 3'h0, 1'b1);
    key(K_COM);
    st(2'h2, 3'h0, 1'b1);
    key(K_INC);
    check("wr", wr_cnt, 0);
    key(K_COM);
    st(2'h0, 3'h0, 1'b1);
    check("data", last_wr, 20'h00201);
    check("nv", nv_cnt, 1);
    key(K_DEC);
    key(K_COM);
    st(2'h2, 3'h0, 1'b1);
    repeat (4) key(K_SEL);
    st(2'h2, 3'h4, 1'b1);
    key(K_DEC);
    check("data", last_wr, 20'h90201);
    key(K_INC);
    check("data", last_wr, 20'h00201);
    key(K_COM);
    check("wr", wr_cnt, 3);
    check("nv", nv_cnt, 2);
    bus(1'b1, REG_NV_SAVE_EN, 32'h0);
    key(K_COM);
    key(K_COM);
    check("nv", nv_cnt, 2);
    bus(1'b1, REG_PW_ENTRY, 32'h0);
    st(2'h0, 3'h0, 1'b0);
    bus(1'b1, REG_PW_DISABLE, 32'h0);
    st(2'h0, 3'h0, 1'b1);
    bus(1'b1, REG_PW_STORED, 32'h7);
    repeat (3) key(K_INC);
    key(K_COM);
    st(2'h1, 3'h0, 1'b1);
    key(K_COM);
    st(2'h0, 3'h0, 1'b1);
    check("wr", wr_cnt, 3);
    op.reset_push(4'hC);
    @(negedge clk);
    check("num", param_num, 20'h00000);
    check("no_app_start", no_app_start, 1'b0);
    bus(1'b0, REG_PW_STORED, 32'h0);
    check("pw", rd, 32'h5);
    s = '0;
    s.sto_active = 1'b1;
    scr(s, 2, 7'h6D, 1'b0, "sto");
    s = '0;
    s.fault = 1'b1;
    s.event_code = 20'h00042;
    scr(s, 5, 7'h71, 1'b0, "fault");
    check("code", seg[1], 7'h66);
    s = '0;
    s.alarm = 1'b1;
    scr(s, 5, 7'h77, 1'b0, "alarm");
    s = '0;
    s.card_xfer = 1'b1;
    scr(s, 0, 7'h7C, 1'b1, "card");
    s = '0;
    s.download = 1'b1;
    scr(s, 0, 7'h5E, 1'b1, "load");
    s = '0;
    s.factory_load = 1'b1;
    scr(s, 0, 7'h73, 1'b1, "factory");
    s.card_erase = 1'b1;
    scr(s, 0, 7'h79, 1'b1, "erase");
    s = '0;
    s.tune_active = 1'b1;
    s.tune_phase = 4'h2;
    scr(s, 0, 7'h5B, 1'b0, "tune");
    s = '0;
    s.tune_done = 1'b1;
    scr(s, 2, 7'h79, 1'b0, "end");
    results();
  end
endmodule : tb_kpm_panel
